// ### shared/cmd_status_defines.svh
// Purpose: Offsets, codes, field positions and reset values of the command/status slave
// Assumes: Included by bare name wherever a constant is needed
// Notes: Definitions only
`ifndef CMD_STATUS_DEFINES_SVH
`define CMD_STATUS_DEFINES_SVH
// Register offsets on the AXI4-Lite side
`define REG_CFG 8'h00
`define REG_RFCTL 8'h04
`define REG_STAT 8'h08
// Reset values
`define CFG_ADDR_RST 7'h50
`define CFG_RO_RST 8'h00
`define CTRL_RST 5'h00
// Command codes
`define OP_MEM_READ 8'h08
`define OP_MEM_WRITE 8'h18
`define OP_REG_READ 8'h68
`define OP_REG_WRITE 8'h78
`define OP_TUNNEL_POLL 8'h88
`define OP_TUNNEL_REPLY 8'h98
// Result codes
`define RES_NONE 4'h0
`define RES_TUN_RD 4'h1
`define RES_TUN_WR 4'h3
`define RES_OK 4'h5
`define RES_BUSY 4'h7
`define RES_BAD_OP 4'h8
`define RES_TUN_ERR 4'h9
`define RES_PARAM 4'ha
`define RES_RO 4'hb
`define RES_HOST_BUSY 4'hf
// Memory size and length limits
`define MEM_BYTES 17'h00100
`define RD_LEN_MAX 8'hfe
`define WR_LEN_MAX 8'hfb
`define LEN_MIN 8'h01
// Frame layout
`define BITS_PER_BYTE 4'h8
`define LAST_BIT 4'h7
`define CTRL_FIXED 3'h4
`endif

// ### shared/cmd_status_pkg.sv
// Purpose: Types shared by the command/status slave
// Assumes: Nothing beyond the language
// Notes: Constants live in the defines header
package cmd_status_pkg;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ADDR = 3'b001,
      S_ACK = 3'b010,
      S_RX = 3'b011,
      S_TX = 3'b100,
      S_TXACK = 3'b101,
      S_SKIP = 3'b110
   } bus_state_t;
endpackage : cmd_status_pkg

// ### shared/bus_lines_if.sv
// Purpose: Conditions seen on the serial lines, passed to the protocol logic
// Assumes: All signals on CLK
// Notes: Pulses last one CLK cycle
`timescale 1ns/10ps
interface bus_lines_if;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic sda;
   modport watch (output scl_rise, scl_fall, start_cond, stop_cond, sda);
   modport user (input scl_rise, scl_fall, start_cond, stop_cond, sda);
endinterface : bus_lines_if

// ### core/line_watch.sv
// Purpose: Synchronise the serial lines and find their edges and bus conditions
// Assumes: Serial clock far slower than CLK
// Notes: Both lines share the same latency, so start and stop keep their order
`timescale 1ns/10ps
module line_watch (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Pins
   input wire logic scl_pin,
   input wire logic sda_pin,
   // Conditions
   bus_lines_if.watch lines
);
   logic scl_s1, scl_s2, scl_s3;
   logic sda_s1, sda_s2, sda_s3;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
      end else begin
         scl_s1 <= scl_pin;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_pin;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
      end
   end

   // Only the second and third stages are looked at
   assign lines.scl_rise = scl_s2 & ~scl_s3;
   assign lines.scl_fall = ~scl_s2 & scl_s3;
   assign lines.start_cond = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign lines.stop_cond = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   assign lines.sda = sda_s2;
endmodule : line_watch

// ### core/cmd_status_slave.sv
// Purpose: Serial slave taking command messages and returning status and responses
// Assumes: Bus master outside; RF side modelled by pins and the RF control register
// Notes: Memory is flip-flops; only the start address is checked against the read-only limit
//
// Contract
// RULE1 - Host masters the bus; device only answers
// RULE2 - Command write executes; result read back afterwards
// RULE3 - Read without command returns current status
// RULE4 - Split commands reassembled, split responses continue
// RULE5 - Host splits data field at most twice
// RULE6 - Address byte then zero to 255 bytes
// RULE7 - Matching address, direction 0: take command bytes
// RULE8 - Matching address, direction 1: send response bytes
// RULE9 - Own address comes from configuration field
// RULE10 - Status bits 7-4 hold four event flags
// RULE11 - Status bits 3-0 hold result code
// RULE12 - Code 0x0 nothing, 0x5 success
// RULE13 - Code 0x1 tunnel read, 0x3 tunnel write
// RULE14 - Code 0x8 for unknown command code
// RULE15 - Code 0xA for bad address or length
// RULE16 - Code 0xB for write into read-only area
// RULE17 - RF busy: read, write, status give 0x7
// RULE18 - Code 0xF while host command incomplete
// RULE19 - Tunnel commands while idle or busy: 0x9
// RULE20 - Control write during RF busy: 0xA
// RULE21 - Codes 0x08, 0x18, 0x68, 0x78 decoded
// RULE22 - Foreign address not acknowledged, frame ignored
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "cmd_status_defines.svh"
module cmd_status_slave
   import cmd_status_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Serial lines
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // RF side
   input wire logic [3:0] RF_EVENT,
   output logic RF_STOP,
   // AXI4-Lite write
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   bus_lines_if lines ();
   bus_state_t state;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic rw, byte_in, byte_out;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_have, w_have;
   logic [6:0] dev_addr;
   logic [7:0] ro_limit;
   logic rf_busy, tun_active, tun_rd, tun_wr;
   logic [3:0] ev_s1, ev_s2, flags;
   logic [4:0] ctrl_w;
   logic [2:0] hdr;
   logic [7:0] op, a_hi, rd_base, len, data_left, wr_ptr, resp_len, resp_idx;
   logic [3:0] pend, result, live_code;
   logic have_resp, resp_reg;
   logic [7:0] mem [0:255];
   logic [7:0] status_byte, ctrl_byte, tx_byte, rd_addr;
   logic tx_is_status;

   function automatic logic reg_hit(input logic [7:0] a);
      return a == `REG_CFG || a == `REG_RFCTL || a == `REG_STAT;
   endfunction : reg_hit

   function automatic logic known_op(input logic [7:0] c);
      return c == `OP_MEM_READ || c == `OP_MEM_WRITE || c == `OP_REG_READ || c == `OP_REG_WRITE ||
             c == `OP_TUNNEL_POLL || c == `OP_TUNNEL_REPLY;
   endfunction : known_op

   function automatic logic [3:0] check_cmd(input logic wr, input logic [15:0] a, input logic [7:0] n,
                                            input logic busy, input logic [7:0] ro);
      logic [16:0] last;
      last = {1'b0, a} + {9'h000, n};
      if (busy)
         return `RES_BUSY; // RULE17
      else if ({1'b0, a} >= `MEM_BYTES || n < `LEN_MIN || n > (wr ? `WR_LEN_MAX : `RD_LEN_MAX) ||
               last > `MEM_BYTES)
         return `RES_PARAM; // RULE15
      else if (wr && a[7:0] < ro)
         return `RES_RO; // RULE16
      else
         return `RES_OK; // RULE12
   endfunction : check_cmd

   line_watch line_watch_inst (
      .clk(CLK),
      .reset(RESET),
      .scl_pin(SCL),
      .sda_pin(SDA_IN),
      .lines(lines)
   );

   // AXI4-Lite write channel; one write at a time
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= 2'b00;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_have <= 1'b1;
            aw_addr <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_have <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         AWREADY <= !aw_have && !(AWVALID && AWREADY) && !BVALID;
         WREADY <= !w_have && !(WVALID && WREADY) && !BVALID;
         if (aw_have && w_have) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= reg_hit(aw_addr) ? 2'b00 : 2'b10;
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // Configuration and RF-side control
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         dev_addr <= `CFG_ADDR_RST;
         ro_limit <= `CFG_RO_RST;
         {tun_wr, tun_rd, tun_active, rf_busy} <= 4'h0;
      end else if (aw_have && w_have) begin
         if (aw_addr == `REG_CFG && w_strb[0])
            dev_addr <= w_data[6:0]; // RULE9
         if (aw_addr == `REG_CFG && w_strb[1])
            ro_limit <= w_data[15:8];
         if (aw_addr == `REG_RFCTL && w_strb[0])
            {tun_wr, tun_rd, tun_active, rf_busy} <= w_data[3:0];
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= 2'b00;
      end else begin
         ARREADY <= !RVALID && !(ARVALID && ARREADY);
         if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= reg_hit(ARADDR) ? 2'b00 : 2'b10;
            if (ARADDR == `REG_CFG)
               RDATA <= {16'h0000, ro_limit, 1'b0, dev_addr};
            else if (ARADDR == `REG_RFCTL)
               RDATA <= {28'h0000000, tun_wr, tun_rd, tun_active, rf_busy};
            else if (ARADDR == `REG_STAT)
               RDATA <= {8'h00, resp_idx, ctrl_byte, status_byte};
            else
               RDATA <= 32'h0000_0000;
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

   // Byte engine; SDA is only ever driven low, and only in answer to the master
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         rw <= 1'b0;
         SDA_OE <= 1'b0;
         SDA_OUT <= 1'b0;
         byte_in <= 1'b0;
         byte_out <= 1'b0;
      end else begin
         byte_in <= 1'b0;
         byte_out <= 1'b0;
         if (lines.stop_cond) begin
            state <= S_IDLE;
            SDA_OE <= 1'b0;
         end else if (lines.start_cond) begin
            state <= S_ADDR; // RULE6
            bit_cnt <= 4'h0;
            SDA_OE <= 1'b0;
         end else begin
            unique case (state)
               S_IDLE, S_SKIP: begin
               end
               S_ADDR, S_RX: begin
                  if (lines.scl_rise && bit_cnt != `BITS_PER_BYTE) begin
                     shift <= {shift[6:0], lines.sda};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (lines.scl_fall && bit_cnt == `BITS_PER_BYTE) begin
                     if (state == S_RX) begin
                        byte_in <= 1'b1; // RULE7
                        SDA_OE <= 1'b1;
                        state <= S_ACK;
                     end else if (shift[7:1] == dev_addr) begin
                        rw <= shift[0]; // RULE9
                        SDA_OE <= 1'b1;
                        state <= S_ACK;
                     end else begin
                        state <= S_SKIP; // RULE22
                     end
                  end
               end
               S_ACK: begin
                  if (lines.scl_fall) begin
                     bit_cnt <= 4'h0;
                     if (rw) begin
                        shift <= tx_byte; // RULE8
                        SDA_OE <= ~tx_byte[7];
                        byte_out <= 1'b1;
                        state <= S_TX;
                     end else begin
                        SDA_OE <= 1'b0;
                        state <= S_RX; // RULE1
                     end
                  end
               end
               S_TX: begin
                  if (lines.scl_fall) begin
                     if (bit_cnt == `LAST_BIT) begin
                        SDA_OE <= 1'b0;
                        state <= S_TXACK;
                     end else begin
                        SDA_OE <= ~shift[6];
                        shift <= {shift[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               S_TXACK: begin
                  if (lines.scl_rise)
                     state <= lines.sda ? S_SKIP : S_ACK;
               end
            endcase
         end
      end
   end

   // Event flags; a new event wins over the clear by a sent status byte
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ev_s1 <= 4'h0;
         ev_s2 <= 4'h0;
         flags <= 4'h0;
      end else begin
         ev_s1 <= RF_EVENT;
         ev_s2 <= ev_s1;
         flags <= (flags & ~((byte_out && tx_is_status) ? flags : 4'h0)) | (ev_s2 & ~ctrl_w[4:1]); // RULE10
      end
   end

   assign tx_is_status = resp_idx == 8'h00 || !have_resp;
   assign ctrl_byte = {ctrl_w, `CTRL_FIXED};
   assign rd_addr = rd_base + resp_idx - 8'h01;
   assign status_byte = {flags, live_code}; // RULE11

   always_comb begin
      if (hdr != 3'h0)
         live_code = `RES_HOST_BUSY; // RULE18
      else if (have_resp)
         live_code = result; // RULE2
      else if (rf_busy)
         live_code = `RES_BUSY; // RULE17
      else if (tun_rd)
         live_code = `RES_TUN_RD; // RULE13
      else if (tun_wr)
         live_code = `RES_TUN_WR; // RULE13
      else
         live_code = `RES_NONE; // RULE3
      if (tx_is_status)
         tx_byte = status_byte;
      else if (resp_reg)
         tx_byte = ctrl_byte;
      else
         tx_byte = mem[rd_addr];
   end

   // Command assembly; progress survives stop and restart, so split frames join up
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         hdr <= 3'h0;
         op <= 8'h00;
         a_hi <= 8'h00;
         rd_base <= 8'h00;
         len <= 8'h00;
         data_left <= 8'h00;
         wr_ptr <= 8'h00;
         pend <= `RES_NONE;
         result <= `RES_NONE;
         have_resp <= 1'b0;
         resp_reg <= 1'b0;
         resp_len <= 8'h00;
         resp_idx <= 8'h00;
         ctrl_w <= `CTRL_RST;
         RF_STOP <= 1'b0;
      end else if (byte_in) begin
         unique case (hdr)
            3'h0: begin
               op <= shift;
               resp_idx <= 8'h00;
               resp_reg <= shift == `OP_REG_READ;
               resp_len <= 8'h00;
               if (shift == `OP_MEM_READ || shift == `OP_MEM_WRITE || shift == `OP_REG_WRITE) begin
                  hdr <= 3'h1; // RULE21
                  have_resp <= 1'b0;
               end else begin
                  have_resp <= 1'b1;
                  if (shift == `OP_REG_READ) begin
                     result <= `RES_OK; // RULE17
                     resp_len <= 8'h01;
                  end else if (!known_op(shift))
                     result <= `RES_BAD_OP; // RULE14
                  else if (!tun_active || rf_busy)
                     result <= `RES_TUN_ERR; // RULE19
                  else
                     result <= `RES_OK;
               end
            end
            3'h1: begin
               if (op == `OP_REG_WRITE) begin
                  hdr <= 3'h0;
                  have_resp <= 1'b1;
                  if (rf_busy) begin
                     result <= `RES_PARAM; // RULE20
                  end else begin
                     result <= `RES_OK;
                     ctrl_w <= shift[7:3];
                     RF_STOP <= shift[3];
                  end
               end else begin
                  a_hi <= shift;
                  hdr <= 3'h2;
               end
            end
            3'h2: begin
               rd_base <= shift;
               wr_ptr <= shift;
               hdr <= 3'h3;
            end
            3'h3: begin
               len <= shift;
               data_left <= shift;
               pend <= check_cmd(op == `OP_MEM_WRITE, {a_hi, rd_base}, shift, rf_busy, ro_limit);
               if (op == `OP_MEM_READ || shift == 8'h00) begin
                  hdr <= 3'h0;
                  have_resp <= 1'b1; // RULE2
                  result <= check_cmd(op == `OP_MEM_WRITE, {a_hi, rd_base}, shift, rf_busy, ro_limit);
                  if (op == `OP_MEM_READ &&
                      check_cmd(1'b0, {a_hi, rd_base}, shift, rf_busy, ro_limit) == `RES_OK)
                     resp_len <= shift;
               end else begin
                  hdr <= 3'h4;
               end
            end
            default: begin
               wr_ptr <= wr_ptr + 8'h01;
               data_left <= data_left - 8'h01;
               if (data_left == 8'h01) begin
                  hdr <= 3'h0; // RULE4
                  have_resp <= 1'b1;
                  result <= pend;
               end
            end
         endcase
      end else if (byte_out) begin
         if (have_resp && resp_idx < resp_len) begin
            resp_idx <= resp_idx + 8'h01; // RULE4
         end else begin
            resp_idx <= 8'h00;
            have_resp <= 1'b0;
         end
      end
   end

   // Data bytes are stored as they arrive, once the header has passed its checks
   always_ff @(posedge CLK) begin
      if (byte_in && hdr == 3'h4 && pend == `RES_OK)
         mem[wr_ptr] <= shift;
   end

   default clocking dc @(posedge CLK); endclocking
   default disable iff (RESET);

   a_foreign_addr_nack: assert property (state == S_ADDR && lines.scl_fall && bit_cnt == `BITS_PER_BYTE && // RULE22
      shift[7:1] != dev_addr |=> state == S_SKIP && !SDA_OE) else $error("foreign address acknowledged");
   a_own_addr_ack: assert property (state == S_ADDR && lines.scl_fall && bit_cnt == `BITS_PER_BYTE && // RULE9
      shift[7:1] == dev_addr |=> SDA_OE && state == S_ACK) else $error("own address not acknowledged");
   a_write_dir_rx: assert property (state == S_ACK && !rw && lines.scl_fall |=> // RULE7
      state == S_RX && !SDA_OE) else $error("write frame did not enter receive");
   a_read_dir_tx: assert property (state == S_ACK && rw && lines.scl_fall |=> // RULE8
      state == S_TX && byte_out && SDA_OE == !$past(tx_byte[7])) else $error("read frame did not send");
   a_quiet_idle: assert property (state == S_IDLE || state == S_SKIP |-> !SDA_OE) // RULE1
      else $error("line driven outside an answer");
   a_host_busy_code: assert property (hdr != 3'h0 |-> status_byte[3:0] == `RES_HOST_BUSY) // RULE18
      else $error("incomplete command not reported busy");
   a_poll_rf_busy: assert property (hdr == 3'h0 && !have_resp && rf_busy |-> status_byte[3:0] == `RES_BUSY) // RULE17
      else $error("status poll during rf work not busy");
   a_bad_op_code: assert property (byte_in && hdr == 3'h0 && !known_op(shift) |=> // RULE14
      have_resp && result == `RES_BAD_OP ##1 status_byte[3:0] == `RES_BAD_OP) else $error("unknown code result");
   a_control_reg_write_cmd_busy_reject: assert property (byte_in && hdr == 3'h1 && op == `OP_REG_WRITE && rf_busy |=> // RULE20
      result == `RES_PARAM && $stable(ctrl_w)) else $error("control write accepted while busy");
   a_flag_sticky: assert property (ev_s2[3] && !ctrl_w[4] ##1 !(byte_out && tx_is_status) |-> // RULE10
      flags[3] ##1 flags[3]) else $error("store event flag lost");

   c_split_write: cover property (byte_in && hdr == 3'h4 && data_left == 8'h01);
   c_read_data: cover property (byte_out && have_resp && resp_idx != 8'h00);
   c_foreign: cover property (state == S_SKIP);
endmodule : cmd_status_slave

// ### tb/host_master_model.sv
// Purpose: Host bus master model on the serial lines
// Assumes: Device pulls SDA low through its enable; lines pulled up
// Notes: Quarter bit is 2 CLK, so SCL period is 160 ns; SCL stays high between frames
`timescale 1ns/10ps
module host_master_model (
   // Clock
   input wire logic clk,
   // Serial lines
   output logic scl,
   output logic sda_rel,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task q;
      repeat (2) @(posedge clk);
   endtask : q
   // Sample mid high phase: the device answers some cycles after our fall
   task bit_io(input logic b, output logic s);
      sda_rel <= b;
      q();
      scl <= 1'b1;
      q();
      s = sda;
      q();
      scl <= 1'b0;
      q();
   endtask : bit_io
   task start_f;
      sda_rel <= 1'b1;
      q();
      scl <= 1'b1;
      q();
      sda_rel <= 1'b0;
      q();
      scl <= 1'b0;
      q();
   endtask : start_f
   task stop_f;
      sda_rel <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      sda_rel <= 1'b1;
      q();
   endtask : stop_f
   task wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : wr_byte
   task rd_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b[i]);
      end
      bit_io(last, s);
   endtask : rd_byte
endmodule : host_master_model

// ### tb/i2c_command_status_slave_bench.sv
// Purpose: Self-checking bench for the command/status serial slave
// Assumes: Host model drives the serial lines; settings made over AXI4-Lite
// Notes: Expects a result once sent to fall back to the current status
`timescale 1ns/10ps
`include "cmd_status_defines.svh"
module i2c_command_status_slave_bench;
   logic clk = 1'b0, reset = 1'b1, scl, sda_rel, sda_oe, rf_stop, sda_out;
   logic [3:0] rf_event = 4'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [6:0] own = `CFG_ADDR_RST;
   wire sda_line;
   int errors = 0, n_checks = 0;
   // Open drain: any enable pulls low, else the pull-up wins
   assign sda_line = (sda_oe | ~sda_rel) ? 1'b0 : 1'b1;
   always #10 clk = ~clk;
   host_master_model host_master_model_inst (.clk(clk), .scl(scl), .sda_rel(sda_rel), .sda(sda_line));
   cmd_status_slave cmd_status_slave_inst (.CLK(clk), .RESET(reset), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out),
      .SDA_OE(sda_oe), .RF_EVENT(rf_event), .RF_STOP(rf_stop), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
      .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task hang(input int k);
      if (k >= 50) begin
         errors++;
         $display("MISMATCH bus answer expected within 50 cycles seen none");
         wrap_up();
      end
   endtask : hang
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      hang(k);
      check("bresp", bresp, er);
   endtask : axi_wr
   task axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int k;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      hang(k);
      check("rresp", rresp, er);
      if (er == 2'b00) check("rdata", rdata, exp);
   endtask : axi_rd
   // Bytes are given most significant first, right aligned
   task wframe(input int n, input logic [47:0] c);
      logic ack;
      host_master_model_inst.start_f();
      host_master_model_inst.wr_byte({own, 1'b0}, ack);
      check("write address ack", ack, 1'b1);
      for (int i = n - 1; i >= 0; i--) begin
         host_master_model_inst.wr_byte(c[8 * i +: 8], ack);
         check("command byte ack", ack, 1'b1);
      end
      host_master_model_inst.stop_f();
   endtask : wframe
   task rframe(input int m, input logic [47:0] r);
      logic ack;
      logic [7:0] v;
      host_master_model_inst.start_f();
      host_master_model_inst.wr_byte({own, 1'b1}, ack);
      check("read address ack", ack, 1'b1);
      for (int i = m - 1; i >= 0; i--) begin
         host_master_model_inst.rd_byte(i == 0, v);
         check("response byte", v, r[8 * i +: 8]);
      end
      host_master_model_inst.stop_f();
   endtask : rframe
   task nack(input logic [6:0] a);
      logic ack;
      host_master_model_inst.start_f();
      host_master_model_inst.wr_byte({a, 1'b1}, ack);
      check("foreign address ack", ack, 1'b0);
      host_master_model_inst.stop_f();
   endtask : nack
   task xact(input int n, input logic [47:0] c, input int m, input logic [47:0] r);
      wframe(n, c);
      rframe(m, r);
   endtask : xact
   task wrap_up;
      $display("Checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      repeat (6) @(posedge clk);
      rframe(1, 48'h00);
      check("sda out", sda_out, 1'b0);
      nack(7'h51);
      axi_rd(`REG_CFG, {16'h0, `CFG_RO_RST, 1'b0, `CFG_ADDR_RST}, 2'b00);
      axi_rd(8'h40, 32'h0, 2'b10);
      axi_wr(8'h40, 32'h0, 2'b10);
      $display("Test reset and polling done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         rf_event <= 4'h1 << i;
         repeat (4) @(posedge clk);
         rf_event <= 4'h0;
         rframe(1, {40'h0, 4'h1 << i, 4'h0});
      end
      rframe(1, 48'h00);
      $display("Test event flags done");
      wframe(2, 48'h1800);
      rframe(1, 48'h0f);
      xact(4, 48'h10025ac3, 1, 48'h05);
      wframe(4, 48'h08001002);
      rframe(2, 48'h055a);
      rframe(1, 48'hc3);
      $display("Test split memory access done");
      axi_wr(`REG_CFG, 32'h0000203a, 2'b00);
      axi_rd(`REG_CFG, 32'h0000203a, 2'b00);
      nack(7'h50);
      own = 7'h3a;
      xact(1, 48'h42, 1, 48'h08);
      xact(4, 48'h08001000, 1, 48'h0a);
      xact(4, 48'h08010001, 1, 48'h0a);
      xact(4, 48'h0800ff02, 1, 48'h0a);
      xact(5, 48'h1800100133, 1, 48'h0b);
      xact(1, 48'h68, 2, 48'h0504);
      xact(2, 48'h7808, 1, 48'h05);
      check("rf stop", rf_stop, 1'b1);
      $display("Test command errors done");
      axi_wr(`REG_RFCTL, 32'h1, 2'b00);
      rframe(1, 48'h07);
      xact(5, 48'h1800300177, 1, 48'h07);
      xact(4, 48'h08001001, 1, 48'h07);
      xact(1, 48'h68, 2, 48'h050c);
      xact(2, 48'h7800, 1, 48'h0a);
      check("rf stop", rf_stop, 1'b1);
      xact(1, 48'h88, 1, 48'h09);
      axi_wr(`REG_RFCTL, 32'h0, 2'b00);
      xact(1, 48'h88, 1, 48'h09);
      axi_wr(`REG_RFCTL, 32'h6, 2'b00);
      rframe(1, 48'h01);
      xact(1, 48'h98, 1, 48'h05);
      axi_wr(`REG_RFCTL, 32'ha, 2'b00);
      rframe(1, 48'h03);
      $display("Test rf busy and tunnel done");
      wrap_up();
   end
endmodule : i2c_command_status_slave_bench
